// ==== src/otp_seq_consts.svh ====
`ifndef OTP_SEQ_CONSTS_SVH
`define OTP_SEQ_CONSTS_SVH

// Clocks
`define CLK_HZ             50000000
`define TICK_HZ            32000
`define TICK_DIV           (`CLK_HZ / `TICK_HZ)

// Times in their own units
`define SLOT_SHORT_US      500
`define SLOT_LONG_US       2000
`define PGOOD_DELAY_US     2000
`define LONG_PRESS_MS      4000
`define RAMP_FAST_NS       2000
`define RAMP_SLOW_NS       4000

// Derived counts: slot and power-good delays in 32 kHz ticks, ramp in clock cycles
`define SLOT_SHORT_TICKS   ((`SLOT_SHORT_US * `TICK_HZ + 999999) / 1000000)
`define SLOT_LONG_TICKS    ((`SLOT_LONG_US * `TICK_HZ + 999999) / 1000000)
`define PGOOD_TICKS        ((`PGOOD_DELAY_US * `TICK_HZ + 999999) / 1000000)
`define LONG_PRESS_TICKS   ((`LONG_PRESS_MS * `TICK_HZ + 999) / 1000)
`define RAMP_FAST_CYC      ((`RAMP_FAST_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define RAMP_SLOW_CYC      ((`RAMP_SLOW_NS * (`CLK_HZ / 1000000) + 999) / 1000)

// Bus target address
`define ADDR_DEFAULT       7'h08
`define ADDR_HIGH_FIXED    4'h1
`define ADDR_USE_DEFAULT   7
`define ADDR_SEL_RESET     8'h00

// Regulator map: 0..2 bucks, 3 boost, 4..7 linear, 8 io rail, 9 card rail
`define NUM_REGS           10
`define THIRD_BUCK_IDX     2
`define BOOST_IDX          3
`define LINEAR_BASE        4
`define IO_RAIL_IDX        8
`define CARD_RAIL_IDX      9

`endif

// ==== src/otp_seq_pkg.sv ====
package otp_seq_pkg;

  typedef struct packed {
    logic [7:0]      addr_sel;
    logic            en_style;
    logic            buck_ramp_select;
    logic            slot_period_sel;
    logic [2:0]      card_rail_slot_code;
    logic [2:0]      io_rail_slot_code;
    logic [3:0][3:0] linear_slot_code;
    logic [2:0]      boost_slot_code;
    logic [2:0][2:0] buck_slot_code;
  } shadow_cfg_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_LOAD,
    ST_SEQ,
    ST_PGWAIT,
    ST_ON
  } seq_state_t;

endpackage : otp_seq_pkg

// ==== src/tick_gen.sv ====
`timescale 1ns/10ps
`include "otp_seq_consts.svh"

module tick_gen #(
  parameter int DIV = `TICK_DIV
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  output logic      o_tick
);

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_r;

  // Refuse at elaboration a divider that cannot make a one-cycle tick
  if (DIV < 2) begin : g_bad_div
    $error("tick_gen: DIV must be at least 2");
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_r == CW'(DIV - 1));
      cnt_r  <= (cnt_r == CW'(DIV - 1)) ? '0 : cnt_r + 1'b1;
    end
  end

  a_tick_single_cycle: assert property (@(posedge i_clk) disable iff (i_rst) o_tick |=> !o_tick)
    else $error("tick lasted more than one cycle");

endmodule : tick_gen

// ==== src/otp_startup_sequencer.sv ====
`timescale 1ns/10ps
`include "otp_seq_consts.svh"

// Behaviour
// - Each regulator has a three or four bit start-up slot code.
// - Slot code zero keeps a regulator off; enable only by write after sequence.
// - Slot period selector picks 500 us or 2000 us between slots.
// - Regulator with slot n turns on n slot periods after turn-on.
// - Sequence stops at the highest slot actually used.
// - Power-good reset output goes high 2.0 ms after the last used slot.
// - Level style: turn-on input high powers on, low powers off.
// - Edge style: falling edge powers on, 4.0 s held low powers off.
// - Bus target address is 0x08..0x0F, bit 3 fixed at one.
// - New bus address takes effect two cycles after the address register write.
// - Bit 7 of the address register forces the default address 0x08.
// - Buck ramp steps every 2.0 us or 4.0 us by ramp selector.
// - At cold start copy fuses into shadow once supply is valid.
// - Every turn-on outside trial mode reloads shadow from fuses before sequencing.
// - Half-supply reference follows the third buck's slot.
// - Regulators already on in sleep stay on through the sequence.
// - Trial mode skips the fuse load and uses current shadow contents.
// - Slot timing derives from the 32 kHz tick.
module otp_startup_sequencer #(
  parameter int TICK_DIV         = `TICK_DIV,
  parameter int LONG_PRESS_TICKS = `LONG_PRESS_TICKS
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_en_pin,
  input  wire logic                       i_supply_ok,
  input  wire logic                       i_trial_mode,
  input  wire otp_seq_pkg::shadow_cfg_t   i_fuse_cfg,
  input  wire logic                       i_shadow_wr,
  input  wire otp_seq_pkg::shadow_cfg_t   i_shadow_wdata,
  input  wire logic                       i_addr_wr,
  input  wire logic [7:0]                 i_addr_wdata,
  input  wire logic                       i_reg_en_wr,
  input  wire logic [`NUM_REGS-1:0]       i_reg_en_wdata,
  input  wire logic [`NUM_REGS-1:0]       i_sleep_keep,
  output logic [`NUM_REGS-1:0]            o_reg_en_r,
  output logic                            o_half_ref_en_r,
  output logic                            o_power_good_reset_out_r,
  output logic [6:0]                      o_bus_addr_r,
  output logic [7:0]                      o_addr_sel_r,
  output otp_seq_pkg::shadow_cfg_t        o_shadow_cfg_r,
  output logic                            o_ramp_step_r,
  output logic                            o_powered_on_r
);

  localparam int LPW = $clog2(LONG_PRESS_TICKS + 1);

  if (LONG_PRESS_TICKS < 1) begin : g_bad_press $error("LONG_PRESS_TICKS must be at least 1"); end
  if (TICK_DIV < 2) begin : g_bad_div $error("TICK_DIV must be at least 2"); end

  otp_seq_pkg::seq_state_t state_r;
  logic [1:0]              en_sync_r;
  logic [1:0]              sup_sync_r;
  logic                    en_prev_r;
  logic                    cold_done_r;
  logic [LPW-1:0]          press_cnt_r;
  logic [6:0]              tick_cnt_r;
  logic [3:0]              slot_cnt_r;
  logic [7:0]              ramp_cnt_r;
  logic                    tick;
  logic                    en_s;
  logic                    sup_s;
  logic                    en_fall;
  logic                    long_press;
  logic                    turn_on;
  logic                    turn_off;
  logic                    slot_adv;
  logic                    pg_done;
  logic [3:0]              slot_nxt;
  logic [3:0]              max_slot;
  logic [6:0]              slot_ticks;
  logic [7:0]              ramp_period;
  logic [3:0]              code [`NUM_REGS];
  logic [`NUM_REGS-1:0]    reg_en_nxt;

  tick_gen #(.DIV(TICK_DIV)) u_tick (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .o_tick (tick)
  );

  // Pin synchronisers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_sync_r  <= 2'h0;
      sup_sync_r <= 2'h0;
      en_prev_r  <= 1'b0;
    end else begin
      en_sync_r  <= {en_sync_r[0], i_en_pin};
      sup_sync_r <= {sup_sync_r[0], i_supply_ok};
      en_prev_r  <= en_sync_r[1];
    end
  end

  assign en_s    = en_sync_r[1];
  assign sup_s   = sup_sync_r[1];
  assign en_fall = en_prev_r & ~en_s;

  // Flatten slot codes; three-bit codes zero-extend to slots 1..7
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_buck
      assign code[gi] = {1'b0, o_shadow_cfg_r.buck_slot_code[gi]};
    end
    for (gi = 0; gi < 4; gi++) begin : g_lin
      assign code[`LINEAR_BASE + gi] = o_shadow_cfg_r.linear_slot_code[gi];
    end
  endgenerate
  assign code[`BOOST_IDX]     = {1'b0, o_shadow_cfg_r.boost_slot_code};
  assign code[`IO_RAIL_IDX]   = {1'b0, o_shadow_cfg_r.io_rail_slot_code};
  assign code[`CARD_RAIL_IDX] = {1'b0, o_shadow_cfg_r.card_rail_slot_code};

  always_comb begin
    max_slot = 4'h0;
    for (int i = 0; i < `NUM_REGS; i++) begin
      if (code[i] > max_slot) max_slot = code[i];
    end
  end

  assign slot_ticks = o_shadow_cfg_r.slot_period_sel ? 7'(`SLOT_LONG_TICKS) : 7'(`SLOT_SHORT_TICKS);
  assign slot_adv   = (state_r == otp_seq_pkg::ST_SEQ) && tick && (tick_cnt_r == slot_ticks - 7'h1);
  assign slot_nxt   = slot_cnt_r + 4'h1;
  assign pg_done    = (state_r == otp_seq_pkg::ST_PGWAIT) && tick && (tick_cnt_r == 7'(`PGOOD_TICKS - 1));

  // Turn-on input decoding
  assign long_press = (press_cnt_r == LPW'(LONG_PRESS_TICKS));
  assign turn_on    = (state_r == otp_seq_pkg::ST_OFF) && sup_s &&
                      (o_shadow_cfg_r.en_style ? en_fall : en_s);
  assign turn_off   = (state_r != otp_seq_pkg::ST_OFF) &&
                      (!sup_s || (o_shadow_cfg_r.en_style ? long_press : !en_s));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      press_cnt_r <= '0;
    end else if (!o_shadow_cfg_r.en_style || en_s || state_r == otp_seq_pkg::ST_OFF) begin
      press_cnt_r <= '0;
    end else if (tick && !long_press) begin
      press_cnt_r <= press_cnt_r + 1'b1;
    end
  end

  // Sequencer state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r    <= otp_seq_pkg::ST_OFF;
      tick_cnt_r <= 7'h0;
      slot_cnt_r <= 4'h0;
    end else if (turn_off) begin
      state_r <= otp_seq_pkg::ST_OFF;
    end else begin
      case (state_r)
        otp_seq_pkg::ST_OFF: begin
          if (turn_on) state_r <= otp_seq_pkg::ST_LOAD;
        end
        otp_seq_pkg::ST_LOAD: begin
          state_r    <= otp_seq_pkg::ST_SEQ;
          tick_cnt_r <= 7'h0;
          slot_cnt_r <= 4'h0;
        end
        otp_seq_pkg::ST_SEQ: begin
          if (max_slot == 4'h0) begin
            state_r    <= otp_seq_pkg::ST_PGWAIT;
            tick_cnt_r <= 7'h0;
          end else if (slot_adv) begin
            tick_cnt_r <= 7'h0;
            slot_cnt_r <= slot_nxt;
            if (slot_nxt >= max_slot) state_r <= otp_seq_pkg::ST_PGWAIT;
          end else if (tick) begin
            tick_cnt_r <= tick_cnt_r + 7'h1;
          end
        end
        otp_seq_pkg::ST_PGWAIT: begin
          if (pg_done) state_r <= otp_seq_pkg::ST_ON;
          else if (tick) tick_cnt_r <= tick_cnt_r + 7'h1;
        end
        otp_seq_pkg::ST_ON: begin
          state_r <= otp_seq_pkg::ST_ON;
        end
        default: state_r <= otp_seq_pkg::ST_OFF;
      endcase
    end
  end

  // Shadow configuration: cold load, reload on turn-on, writes only when idle or on
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_shadow_cfg_r <= '0;
      cold_done_r    <= 1'b0;
    end else begin
      cold_done_r <= sup_s;
      if (sup_s && !cold_done_r) begin
        o_shadow_cfg_r <= i_fuse_cfg;
      end else if (state_r == otp_seq_pkg::ST_LOAD && !i_trial_mode) begin
        o_shadow_cfg_r <= i_fuse_cfg;
      end else if (i_shadow_wr && (state_r == otp_seq_pkg::ST_OFF || state_r == otp_seq_pkg::ST_ON)) begin
        o_shadow_cfg_r <= i_shadow_wdata;
      end
    end
  end

  // Regulator enables
  generate
    for (gi = 0; gi < `NUM_REGS; gi++) begin : g_en
      always_comb begin
        if (turn_off) begin
          reg_en_nxt[gi] = i_sleep_keep[gi];
        end else if (slot_adv && code[gi] == slot_nxt && code[gi] != 4'h0) begin
          reg_en_nxt[gi] = 1'b1;
        end else if (state_r == otp_seq_pkg::ST_ON && i_reg_en_wr) begin
          reg_en_nxt[gi] = i_reg_en_wdata[gi];
        end else begin
          reg_en_nxt[gi] = o_reg_en_r[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_en_r      <= '0;
      o_half_ref_en_r <= 1'b0;
    end else begin
      o_reg_en_r      <= reg_en_nxt;
      o_half_ref_en_r <= reg_en_nxt[`THIRD_BUCK_IDX];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_power_good_reset_out_r <= 1'b0;
      o_powered_on_r           <= 1'b0;
    end else begin
      if (turn_off) o_power_good_reset_out_r <= 1'b0;
      else if (pg_done) o_power_good_reset_out_r <= 1'b1;
      if (turn_off) o_powered_on_r <= 1'b0;
      else if (turn_on) o_powered_on_r <= 1'b1;
    end
  end

  // Bus address selection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_addr_sel_r <= `ADDR_SEL_RESET;
      o_bus_addr_r <= `ADDR_DEFAULT;
    end else begin
      if (state_r == otp_seq_pkg::ST_LOAD && !i_trial_mode) o_addr_sel_r <= i_fuse_cfg.addr_sel;
      else if (i_addr_wr) o_addr_sel_r <= i_addr_wdata;
      if (o_addr_sel_r[`ADDR_USE_DEFAULT]) o_bus_addr_r <= `ADDR_DEFAULT;
      else o_bus_addr_r <= {3'h0, `ADDR_HIGH_FIXED} << 3 | {4'h0, o_addr_sel_r[2:0]};
    end
  end

  // Buck soft-start step strobe
  assign ramp_period = o_shadow_cfg_r.buck_ramp_select ? 8'(`RAMP_SLOW_CYC) : 8'(`RAMP_FAST_CYC);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ramp_cnt_r    <= 8'h0;
      o_ramp_step_r <= 1'b0;
    end else begin
      o_ramp_step_r <= (ramp_cnt_r >= ramp_period - 8'h1);
      ramp_cnt_r    <= (ramp_cnt_r >= ramp_period - 8'h1) ? 8'h0 : ramp_cnt_r + 8'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_turn_on;
    state_r == otp_seq_pkg::ST_OFF && turn_on;
  endsequence

  sequence s_load_then_seq;
    state_r == otp_seq_pkg::ST_LOAD ##1 state_r == otp_seq_pkg::ST_SEQ;
  endsequence

  a_turn_on_load: assert property (s_turn_on ##1 !turn_off |-> s_load_then_seq or turn_off)
    else $error("turn-on did not pass through load");
  a_fuse_reload: assert property (state_r == otp_seq_pkg::ST_LOAD && !i_trial_mode && !turn_off
    |=> o_shadow_cfg_r == $past(i_fuse_cfg))
    else $error("shadow not reloaded from fuses");
  a_trial_keep: assert property (state_r == otp_seq_pkg::ST_LOAD && i_trial_mode
    |=> o_shadow_cfg_r == $past(o_shadow_cfg_r))
    else $error("trial mode altered shadow");
  a_cold_load: assert property (sup_s && !cold_done_r |=> o_shadow_cfg_r == $past(i_fuse_cfg))
    else $error("cold start load missing");
  a_slot_short: assert property (slot_adv && !o_shadow_cfg_r.slot_period_sel |-> tick_cnt_r == 7'd15)
    else $error("short slot period wrong");
  a_slot_long: assert property (slot_adv && o_shadow_cfg_r.slot_period_sel |-> tick_cnt_r == 7'd63)
    else $error("long slot period wrong");
  a_seq_bound: assert property (state_r == otp_seq_pkg::ST_SEQ |-> slot_cnt_r < max_slot || max_slot == 4'h0)
    else $error("sequence ran past last used slot");
  a_pgood_delay: assert property (pg_done && !turn_off |=> o_power_good_reset_out_r && tick_cnt_r == 7'd63)
    else $error("power-good not released after delay");
  a_level_off: assert property (state_r != otp_seq_pkg::ST_OFF && !o_shadow_cfg_r.en_style && !en_s
    |=> state_r == otp_seq_pkg::ST_OFF && !o_power_good_reset_out_r)
    else $error("level low did not power off");
  a_long_off: assert property (state_r != otp_seq_pkg::ST_OFF && o_shadow_cfg_r.en_style && long_press
    |=> state_r == otp_seq_pkg::ST_OFF)
    else $error("long press did not power off");
  a_addr_default: assert property (o_addr_sel_r[7] |=> o_bus_addr_r == 7'h08)
    else $error("default address not forced");
  a_addr_range: assert property (o_bus_addr_r[6:3] == 4'h1)
    else $error("bus address out of range");
  a_addr_follow: assert property (i_addr_wr && !i_addr_wdata[7] && state_r != otp_seq_pkg::ST_LOAD
    |=> ##1 o_bus_addr_r == {4'h1, $past(i_addr_wdata[2:0], 2)})
    else $error("new bus address not applied");
  a_half_ref: assert property (o_half_ref_en_r == o_reg_en_r[2])
    else $error("half reference not tied to third buck");
  a_no_drop: assert property (state_r != otp_seq_pkg::ST_OFF && state_r != otp_seq_pkg::ST_ON && !turn_off
    |=> (o_reg_en_r & $past(o_reg_en_r)) == $past(o_reg_en_r))
    else $error("enabled regulator cycled during sequence");
  a_shadow_wr_quiet: assert property (i_shadow_wr && state_r == otp_seq_pkg::ST_ON && !turn_off && !i_reg_en_wr
    |=> state_r == otp_seq_pkg::ST_ON && o_reg_en_r == $past(o_reg_en_r))
    else $error("shadow write disturbed sequence");

  generate
    for (gi = 0; gi < `NUM_REGS; gi++) begin : g_chk
      a_slot_match: assert property ($rose(o_reg_en_r[gi]) && $past(state_r) == otp_seq_pkg::ST_SEQ
        |-> code[gi] == slot_cnt_r && code[gi] != 4'h0)
        else $error("regulator enabled outside its slot");
    end
  endgenerate

endmodule : otp_startup_sequencer

// ==== testbench/rail_monitor.sv ====
`timescale 1ns/10ps
`include "otp_seq_consts.svh"

// Stands in for the rail loads and host reset pin: stamps every enable or power-good change it sees
module rail_monitor (
  input  wire logic                 i_clk,
  input  wire logic [`NUM_REGS-1:0] i_en,
  input  wire logic                 i_pg,
  input  wire logic                 i_half,
  output logic                      o_evt_r,
  output logic [`NUM_REGS-1:0]      o_en_r,
  output logic                      o_pg_r,
  output logic                      o_half_r,
  output logic [31:0]               o_stamp_r
);
  logic [`NUM_REGS-1:0] prev_en_r;
  logic                 prev_pg_r;

  initial begin
    o_stamp_r = 32'h0;
    prev_en_r = '0;
    prev_pg_r = 1'b0;
    o_evt_r   = 1'b0;
  end

  always @(posedge i_clk) begin
    o_stamp_r <= o_stamp_r + 32'h1;
    o_evt_r   <= (i_en !== prev_en_r) || (i_pg !== prev_pg_r);
    prev_en_r <= i_en;
    prev_pg_r <= i_pg;
    o_en_r    <= i_en;
    o_pg_r    <= i_pg;
    o_half_r  <= i_half;
  end
endmodule : rail_monitor

// ==== testbench/otp_startup_sequencer_tb.sv ====
`timescale 1ns/10ps
`include "otp_seq_consts.svh"

module otp_startup_sequencer_tb;
  typedef struct packed {
    logic [`NUM_REGS-1:0] en;
    logic                 pg;
    logic [31:0]          t;
  } exp_t;
  localparam int TD  = 4;
  localparam int LP  = 20;
  localparam int OFS = 8;
  localparam int TOL = 10;
  logic                     i_clk, i_rst, i_en_pin, i_supply_ok, i_trial_mode;
  logic                     i_shadow_wr, i_addr_wr, i_reg_en_wr;
  otp_seq_pkg::shadow_cfg_t i_fuse_cfg, i_shadow_wdata, o_shadow_cfg_r, f, w;
  logic [7:0]               i_addr_wdata, o_addr_sel_r;
  logic [`NUM_REGS-1:0]     i_reg_en_wdata, i_sleep_keep, o_reg_en_r, keep, v, evt_en;
  logic                     o_half_ref_en_r, o_power_good_reset_out_r, o_ramp_step_r, o_powered_on_r;
  logic [6:0]               o_bus_addr_r;
  logic                     evt, evt_pg, evt_half;
  logic [31:0]              stamp;
  exp_t                     exp_q[$];
  integer                   seed, miscompares, cmp_count;

  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;

  otp_startup_sequencer #(.TICK_DIV(TD), .LONG_PRESS_TICKS(LP)) otp_startup_sequencer_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_en_pin(i_en_pin), .i_supply_ok(i_supply_ok),
    .i_trial_mode(i_trial_mode), .i_fuse_cfg(i_fuse_cfg), .i_shadow_wr(i_shadow_wr),
    .i_shadow_wdata(i_shadow_wdata), .i_addr_wr(i_addr_wr), .i_addr_wdata(i_addr_wdata),
    .i_reg_en_wr(i_reg_en_wr), .i_reg_en_wdata(i_reg_en_wdata), .i_sleep_keep(i_sleep_keep),
    .o_reg_en_r(o_reg_en_r), .o_half_ref_en_r(o_half_ref_en_r),
    .o_power_good_reset_out_r(o_power_good_reset_out_r), .o_bus_addr_r(o_bus_addr_r),
    .o_addr_sel_r(o_addr_sel_r), .o_shadow_cfg_r(o_shadow_cfg_r), .o_ramp_step_r(o_ramp_step_r),
    .o_powered_on_r(o_powered_on_r));

  rail_monitor rail_monitor_i (.i_clk(i_clk), .i_en(o_reg_en_r), .i_pg(o_power_good_reset_out_r),
    .i_half(o_half_ref_en_r), .o_evt_r(evt), .o_en_r(evt_en), .o_pg_r(evt_pg), .o_half_r(evt_half),
    .o_stamp_r(stamp));

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  function automatic int r(input int m);
    return $unsigned($random(seed)) % m;
  endfunction : r

  function automatic logic [3:0] code_of(input otp_seq_pkg::shadow_cfg_t c, input int k);
    if (k < `BOOST_IDX) return {1'b0, c.buck_slot_code[k]};
    if (k == `BOOST_IDX) return {1'b0, c.boost_slot_code};
    if (k < `IO_RAIL_IDX) return c.linear_slot_code[k-`LINEAR_BASE];
    if (k == `IO_RAIL_IDX) return {1'b0, c.io_rail_slot_code};
    return {1'b0, c.card_rail_slot_code};
  endfunction : code_of

  task automatic rand_cfg(output otp_seq_pkg::shadow_cfg_t c, input logic st, input logic sel,
                          input logic rp, input int m3, input int m4);
    c.addr_sel            = 8'(r(256));
    c.en_style            = st;
    c.slot_period_sel     = sel;
    c.buck_ramp_select    = rp;
    c.card_rail_slot_code = 3'(r(m3));
    c.io_rail_slot_code   = 3'(r(m3));
    c.boost_slot_code     = 3'(r(m3));
    for (int k = 0; k < 3; k++) c.buck_slot_code[k] = 3'(r(m3));
    for (int k = 0; k < 4; k++) c.linear_slot_code[k] = 4'(r(m4));
  endtask : rand_cfg

  // Notes one event per slot that changes the enables, then power-good after the last used slot
  task automatic plan_seq(input otp_seq_pkg::shadow_cfg_t c, input logic [`NUM_REGS-1:0] v0);
    logic [`NUM_REGS-1:0] pv, nv;
    int                   p, last;
    nv   = v0;
    last = 0;
    p    = c.slot_period_sel ? 64 * TD : 16 * TD;
    for (int n = 1; n < 16; n++) begin
      pv = nv;
      for (int k = 0; k < `NUM_REGS; k++) if (code_of(c, k) == n) nv[k] = 1'b1;
      for (int k = 0; k < `NUM_REGS; k++) if (code_of(c, k) == n) last = n;
      if (nv != pv) exp_q.push_back('{nv, 1'b0, stamp + n * p + OFS});
    end
    exp_q.push_back('{nv, 1'b1, stamp + last * p + 64 * TD + OFS});
  endtask : plan_seq

  task automatic drain(input int lim);
    int c;
    c = 0;
    while (exp_q.size() != 0 && c < lim) begin
      step(1);
      c++;
    end
    chk("events_left", 0, exp_q.size());
    step(20);
  endtask : drain

  task automatic wr_shadow(input otp_seq_pkg::shadow_cfg_t c);
    i_shadow_wdata = c;
    i_shadow_wr    = 1'b1;
    step(1);
    i_shadow_wr = 1'b0;
    step(2);
  endtask : wr_shadow

  task automatic ramp_period(input logic sel);
    int c;
    c = 0;
    while (o_ramp_step_r !== 1'b1 && c < 500) begin
      step(1);
      c++;
    end
    step(1);
    c = 1;
    while (o_ramp_step_r !== 1'b1 && c < 500) begin
      step(1);
      c++;
    end
    chk("ramp_period", sel ? 200 : 100, c);
  endtask : ramp_period

  always @(posedge i_clk) begin : watch
    exp_t e;
    if (evt === 1'b1 && i_rst === 1'b0) begin
      if (exp_q.size() == 0) chk("unexpected_event", 0, 1);
      else begin
        e = exp_q.pop_front();
        chk("reg_en", e.en, evt_en);
        chk("power_good", e.pg, evt_pg);
        chk("half_ref", evt_en[`THIRD_BUCK_IDX], evt_half);
        chk("event_time", 1, (stamp - e.t + TOL) <= 2 * TOL);
      end
    end
  end

  // Whole run is under 4000 cycles; this allows more than five times that
  initial begin
    #400000;
    miscompares++;
    close_out();
  end

  initial begin
    seed = 2;
    miscompares = 0;
    cmp_count = 0;
    {i_rst, i_en_pin, i_supply_ok, i_trial_mode, i_shadow_wr, i_addr_wr, i_reg_en_wr} = 7'h40;
    {i_fuse_cfg, i_shadow_wdata, i_addr_wdata, i_reg_en_wdata, i_sleep_keep} = '0;
    step(4);
    i_rst = 1'b0;
    step(2);
    chk("bus_addr_rst", 7'h08, o_bus_addr_r);
    chk("addr_sel_rst", 8'h00, o_addr_sel_r);
    for (int i = 0; i < 16; i++) begin
      i_addr_wdata = {i[3], 4'(r(16)), i[2:0]};
      i_addr_wr = 1'b1;
      step(1);
      i_addr_wr = 1'b0;
      step(1);
      chk("addr_sel", i_addr_wdata, o_addr_sel_r);
      step(1);
      chk("bus_addr", i[3] ? 7'h08 : {4'h1, i[2:0]}, o_bus_addr_r);
    end
    rand_cfg(f, 1'b0, 1'b0, 1'b0, 8, 16);
    f.linear_slot_code[3] = 4'hf;
    f.buck_slot_code[0] = 3'h7;
    f.card_rail_slot_code = 3'h0;
    i_fuse_cfg = f;
    i_supply_ok = 1'b1;
    step(10);
    chk("shadow_cold", f, o_shadow_cfg_r);
    rand_cfg(w, 1'b0, 1'b0, 1'b1, 8, 16);
    wr_shadow(w);
    chk("shadow_wr", w, o_shadow_cfg_r);
    plan_seq(f, '0);
    i_en_pin = 1'b1;
    drain(2000);
    chk("shadow_reload", f, o_shadow_cfg_r);
    chk("addr_sel_load", f.addr_sel, o_addr_sel_r);
    chk("bus_addr_load", f.addr_sel[7] ? 7'h08 : {4'h1, f.addr_sel[2:0]}, o_bus_addr_r);
    chk("powered_on", 1'b1, o_powered_on_r);
    wr_shadow(w);
    step(40);
    chk("shadow_on_wr", w, o_shadow_cfg_r);
    v = 10'(r(1024)) | 10'h200;
    exp_q.push_back('{v, 1'b1, stamp + 3});
    i_reg_en_wdata = v;
    i_reg_en_wr = 1'b1;
    step(1);
    i_reg_en_wr = 1'b0;
    drain(30);
    keep = 10'(r(1024));
    i_sleep_keep = keep;
    exp_q.push_back('{keep, 1'b0, stamp + 4});
    i_en_pin = 1'b0;
    drain(40);
    chk("powered_off", 1'b0, o_powered_on_r);
    rand_cfg(w, 1'b0, 1'b0, 1'b1, 4, 5);
    wr_shadow(w);
    i_trial_mode = 1'b1;
    plan_seq(w, keep);
    i_en_pin = 1'b1;
    drain(1000);
    chk("shadow_trial", w, o_shadow_cfg_r);
    chk("addr_sel_trial", f.addr_sel, o_addr_sel_r);
    ramp_period(1'b1);
    i_trial_mode = 1'b0;
    i_sleep_keep = '0;
    exp_q.push_back('{10'h0, 1'b0, stamp + 4});
    i_supply_ok = 1'b0;
    i_en_pin = 1'b0;
    drain(40);
    rand_cfg(f, 1'b1, 1'b1, 1'b0, 4, 4);
    i_fuse_cfg = f;
    i_supply_ok = 1'b1;
    step(10);
    chk("shadow_cold2", f, o_shadow_cfg_r);
    i_en_pin = 1'b1;
    step(30);
    plan_seq(f, '0);
    i_en_pin = 1'b0;
    step(5);
    i_en_pin = 1'b1;
    wr_shadow(w);
    drain(1500);
    chk("shadow_refused", f, o_shadow_cfg_r);
    ramp_period(1'b0);
    exp_q.push_back('{10'h0, 1'b0, stamp + 4 * LP + 4});
    i_en_pin = 1'b0;
    drain(200);
    close_out();
  end
endmodule : otp_startup_sequencer_tb
